// file: design/pmm_pkg.sv
// Constants for the transceiver management and transmit-disable block.
// Assumes a 20 MHz system clock; all pins arrive asynchronously.
package pmm_pkg;
    // Two-wire device addresses, 7-bit form of A0h and A2h
    localparam logic [6:0] DEV_ID = 7'h50;
    localparam logic [6:0] DEV_DIAG = 7'h51;
    // Diagnostic page layout
    localparam logic [7:0] CTRL_OFFSET = 8'h6e;
    localparam logic [7:0] MON_BASE = 8'h60;
    localparam logic [7:0] MON_BYTES = 8'h0a;
    // Control/status byte fields
    localparam int BIT_PIN_STATE = 7;
    localparam int BIT_SOFT_DIS = 6;
    localparam int BIT_FAULT = 2;
    localparam int BIT_SIG_LOST = 1;
    localparam logic SOFT_DIS_RESET = 1'b0;
    // Synchroniser lanes
    localparam int LANES = 5;
    localparam int L_SCL = 0;
    localparam int L_SDA = 1;
    localparam int L_TXOFF = 2;
    localparam int L_FAULT = 3;
    localparam int L_LOSS = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Two-wire slave states, Gray coded in declaration order; PMM_ADDR_ACK to PMM_READ flips three bits
    typedef enum logic [3:0] {
        PMM_IDLE = 4'h0,
        PMM_ADDR = 4'h1,
        PMM_ADDR_ACK = 4'h3,
        PMM_WORD = 4'h2,
        PMM_WORD_ACK = 4'h6,
        PMM_WRITE = 4'h7,
        PMM_WRITE_ACK = 4'h5,
        PMM_READ = 4'h4,
        PMM_READ_ACK = 4'hc
    } pmm_state_t;
endpackage

// file: design/pmm_mgmt.sv
// Two-wire management slave with ID and diagnostic pages, plus transmit
// disable and fault latch. Assumes host pulls sda, scl and txOffPin up
// externally; the pull-up on txOffPin stands outside this logic.
//
// What this block does
// RL1: Serve 256-byte ID page at A0h
// RL2: Serve 256-byte diagnostic page at A2h
// RL3: Expose live voltage, temperature, bias, powers
// RL4: Transmit-off pin high shuts laser down
// RL5: Pin defaults disabled; host must drive low
// RL6: Pin high-then-low clears fault, retries laser
// RL7: Byte 110 bit 6 is software disable
// RL8: Byte 110 bit 7 mirrors pin, read-only
// RL9: Disable is OR of pin and software
// RL10: Software disable clears on power cycle
// RL11: Pin and signal loss mirrored in memory
// RL12: Laser fault latches output, disables laser
// RL13: Latched fault readable at byte 110 bit 2
// RL14: Signal loss output high, byte 110 bit 1
// RL15: Ack only A0h/A2h; reads auto-increment
// RL16: Writes to read-only status bits ignored
`timescale 1ns/100ps
module pmm_mgmt (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic txOffPin,
    input wire logic laserFaultIn,
    input wire logic lossDetectIn,
    input wire logic [15:0] supplyVoltage,
    input wire logic [15:0] temperature,
    input wire logic [15:0] laserBias,
    input wire logic [15:0] txPower,
    input wire logic [15:0] rxPower,
    output logic laserEnable,
    output logic txFaultOut,
    output logic txFaultOe,
    output logic receiveSignalLost
);
    logic [pmm_pkg::LANES-1:0] pinMeta;
    logic [pmm_pkg::LANES-1:0] pinSync;
    logic [pmm_pkg::LANES-1:0] pinPrev;
    pmm_pkg::pmm_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] offset;
    logic [7:0] txByte;
    logic pageDiag;
    logic readDir;
    logic masterNack;
    logic softDisable;
    logic faultLatched;
    logic [7:0] idMem [0:255];
    logic [7:0] diagMem [0:255];
    logic [15:0] monVal [0:4];

    // Sampled pins; only pinSync and pinPrev feed logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinMeta <= 5'h07;
            pinSync <= 5'h07;
            pinPrev <= 5'h07;
        end else begin
            pinMeta <= {lossDetectIn, laserFaultIn, txOffPin, sdaIn, sclIn};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    wire sclNow = pinSync[pmm_pkg::L_SCL];
    wire sdaNow = pinSync[pmm_pkg::L_SDA];
    wire txOffSync = pinSync[pmm_pkg::L_TXOFF];
    wire faultSync = pinSync[pmm_pkg::L_FAULT];
    wire signalLostStatus = pinSync[pmm_pkg::L_LOSS];
    wire sclRise = sclNow & ~pinPrev[pmm_pkg::L_SCL];
    wire sclFall = ~sclNow & pinPrev[pmm_pkg::L_SCL];
    wire startCond = sclNow & pinPrev[pmm_pkg::L_SCL] & pinPrev[pmm_pkg::L_SDA] & ~sdaNow;
    wire stopCond = sclNow & pinPrev[pmm_pkg::L_SCL] & ~pinPrev[pmm_pkg::L_SDA] & sdaNow;
    wire txOffFall = pinPrev[pmm_pkg::L_TXOFF] & ~txOffSync;
    wire byteDone = (bitCnt == pmm_pkg::BITS_PER_BYTE);
    wire addrMatch = (shiftReg[7:1] == pmm_pkg::DEV_ID) || (shiftReg[7:1] == pmm_pkg::DEV_DIAG);
    wire doWrite = (state == pmm_pkg::PMM_WRITE) && sclFall && byteDone;
    wire doLoad = sclFall && (((state == pmm_pkg::PMM_ADDR_ACK) && readDir)
        || ((state == pmm_pkg::PMM_READ_ACK) && !masterNack));
    wire isCtrl = pageDiag && (offset == pmm_pkg::CTRL_OFFSET);
    wire isMon = pageDiag && (offset >= pmm_pkg::MON_BASE)
        && (offset < pmm_pkg::MON_BASE + pmm_pkg::MON_BYTES);
    wire txDisableEff = txOffSync | softDisable; // see RL9

    // Status bits come from live state, never from stored memory
    logic [7:0] ctrlByte;
    always_comb begin
        ctrlByte = 8'h00;
        ctrlByte[pmm_pkg::BIT_PIN_STATE] = txOffSync; // see RL8
        ctrlByte[pmm_pkg::BIT_SOFT_DIS] = softDisable; // see RL7
        ctrlByte[pmm_pkg::BIT_FAULT] = faultLatched; // see RL13
        ctrlByte[pmm_pkg::BIT_SIG_LOST] = signalLostStatus; // see RL14
    end

    assign monVal[0] = temperature; // see RL3
    assign monVal[1] = supplyVoltage;
    assign monVal[2] = laserBias;
    assign monVal[3] = txPower;
    assign monVal[4] = rxPower;

    // Plain wires, not a function, so live monitor changes reach readByte
    wire [7:0] monIdx = offset - pmm_pkg::MON_BASE;
    wire [15:0] monWord = monVal[monIdx[3:1]];
    wire [7:0] monPick = monIdx[0] ? monWord[7:0] : monWord[15:8];

    wire [7:0] readByte = !pageDiag ? idMem[offset] : // see RL1
        isCtrl ? ctrlByte : // see RL11
        isMon ? monPick : diagMem[offset]; // see RL2

    // Two-wire slave; sda changes only after scl falls
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= pmm_pkg::PMM_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            offset <= 8'h00;
            txByte <= 8'h00;
            pageDiag <= 1'b0;
            readDir <= 1'b0;
            masterNack <= 1'b0;
            sdaOe <= 1'b0;
        end else if (startCond) begin
            state <= pmm_pkg::PMM_ADDR;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            state <= pmm_pkg::PMM_IDLE;
            sdaOe <= 1'b0;
        end else if (sclRise) begin
            if (state == pmm_pkg::PMM_READ_ACK) begin
                masterNack <= sdaNow;
            end else if (!byteDone) begin
                shiftReg <= {shiftReg[6:0], sdaNow};
                bitCnt <= bitCnt + 4'h1;
            end
        end else if (sclFall) begin
            case (state)
                pmm_pkg::PMM_ADDR: begin
                    if (byteDone) begin
                        sdaOe <= addrMatch; // see RL15
                        state <= addrMatch ? pmm_pkg::PMM_ADDR_ACK : pmm_pkg::PMM_IDLE;
                        pageDiag <= shiftReg[1];
                        readDir <= shiftReg[0];
                    end
                end
                pmm_pkg::PMM_ADDR_ACK: begin
                    bitCnt <= 4'h0;
                    if (readDir) begin
                        txByte <= readByte;
                        offset <= offset + 8'h01; // see RL15
                        sdaOe <= ~readByte[7];
                        state <= pmm_pkg::PMM_READ;
                    end else begin
                        sdaOe <= 1'b0;
                        state <= pmm_pkg::PMM_WORD;
                    end
                end
                pmm_pkg::PMM_WORD: begin
                    if (byteDone) begin
                        offset <= shiftReg;
                        sdaOe <= 1'b1;
                        state <= pmm_pkg::PMM_WORD_ACK;
                    end
                end
                pmm_pkg::PMM_WRITE: begin
                    if (byteDone) begin
                        offset <= offset + 8'h01;
                        sdaOe <= 1'b1;
                        state <= pmm_pkg::PMM_WRITE_ACK;
                    end
                end
                pmm_pkg::PMM_WORD_ACK, pmm_pkg::PMM_WRITE_ACK: begin
                    bitCnt <= 4'h0;
                    sdaOe <= 1'b0;
                    state <= pmm_pkg::PMM_WRITE;
                end
                pmm_pkg::PMM_READ: begin
                    if (byteDone) begin
                        sdaOe <= 1'b0;
                        state <= pmm_pkg::PMM_READ_ACK;
                    end else begin
                        sdaOe <= ~txByte[3'h7 - bitCnt[2:0]];
                    end
                end
                pmm_pkg::PMM_READ_ACK: begin
                    bitCnt <= 4'h0;
                    if (masterNack) begin
                        sdaOe <= 1'b0;
                        state <= pmm_pkg::PMM_IDLE;
                    end else begin
                        txByte <= readByte;
                        offset <= offset + 8'h01;
                        sdaOe <= ~readByte[7];
                        state <= pmm_pkg::PMM_READ;
                    end
                end
                default: begin
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    assign sdaOut = 1'b0;

    // Page storage; live monitor and control bytes are not stored
    always_ff @(posedge clk) begin
        if (doWrite && !pageDiag) begin
            idMem[offset] <= shiftReg;
        end
        if (doWrite && pageDiag && !isCtrl && !isMon) begin
            diagMem[offset] <= shiftReg;
        end
    end

    // Sync reset stands for power cycle and hot plug
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            softDisable <= pmm_pkg::SOFT_DIS_RESET; // see RL10
        end else if (doWrite && isCtrl) begin
            softDisable <= shiftReg[pmm_pkg::BIT_SOFT_DIS]; // see RL7 and RL16
        end
    end

    // Set wins over the clearing toggle, so a persisting fault stays caught
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faultLatched <= 1'b0;
        end else if (faultSync) begin
            faultLatched <= 1'b1; // see RL12
        end else if (txOffFall) begin
            faultLatched <= 1'b0; // see RL6
        end
    end

    // Pin idles high after reset, so the laser stays off until host drives low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            laserEnable <= 1'b0;
            txFaultOe <= 1'b1;
            receiveSignalLost <= 1'b0;
        end else begin
            laserEnable <= ~txDisableEff & ~faultLatched & ~faultSync; // see RL4 and RL5
            txFaultOe <= ~faultLatched & ~faultSync; // see RL12
            receiveSignalLost <= signalLostStatus; // see RL14
        end
    end

    // Open-collector fault: pulled low while healthy, released on fault
    assign txFaultOut = 1'b0;

    property p_or_disable;
        @(posedge clk) disable iff (sys_rst)
        (txOffSync || softDisable) |=> !laserEnable;
    endproperty
    a_or_disable: assert property (p_or_disable) else $error("laser on while disabled"); // see RL9

    property p_enable;
        @(posedge clk) disable iff (sys_rst)
        (!txOffSync && !softDisable && !faultLatched && !faultSync) |=> laserEnable;
    endproperty
    a_enable: assert property (p_enable) else $error("laser off without cause"); // see RL4

    property p_fault_set;
        @(posedge clk) disable iff (sys_rst)
        faultSync |=> faultLatched && !laserEnable ##1 !txFaultOe;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not latched"); // see RL12

    property p_fault_hold;
        @(posedge clk) disable iff (sys_rst)
        (faultLatched && !txOffFall) |=> faultLatched;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault dropped early"); // see RL12

    property p_fault_clear;
        @(posedge clk) disable iff (sys_rst)
        (faultLatched && txOffFall && !faultSync) |=> !faultLatched ##1 txFaultOe;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("toggle did not clear"); // see RL6

    property p_soft_reset;
        @(posedge clk)
        sys_rst |=> !softDisable;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft disable kept"); // see RL10

    property p_signal_lost;
        @(posedge clk) disable iff (sys_rst)
        $changed(signalLostStatus) |=> receiveSignalLost == $past(signalLostStatus);
    endproperty
    a_signal_lost: assert property (p_signal_lost) else $error("loss output lags"); // see RL14

    property p_no_ack;
        @(posedge clk) disable iff (sys_rst)
        (sclFall && state == pmm_pkg::PMM_ADDR && byteDone && !addrMatch && !startCond && !stopCond)
            |=> !sdaOe && state == pmm_pkg::PMM_IDLE;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("foreign address acked"); // see RL15

    property p_ctrl_write;
        @(posedge clk) disable iff (sys_rst)
        (doWrite && isCtrl && !startCond && !stopCond && !faultSync && !txOffFall)
            |=> softDisable == $past(shiftReg[pmm_pkg::BIT_SOFT_DIS]) && faultLatched == $past(faultLatched);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong"); // see RL16

    property p_read_inc;
        @(posedge clk) disable iff (sys_rst)
        (doLoad && !startCond && !stopCond) |=> offset == $past(offset) + 8'h01;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("offset not advanced"); // see RL15
endmodule

// file: bench/pmm_host_model.sv
// Two-wire host master model for the management slave.
// Assumes sdaWire is the resolved data line with its pull-up applied.
`timescale 1ns/100ps
module pmm_host_model (
    input wire logic clk,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaPull
);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    // Steps of 50 ns keep every edge just after a clk rise
    task automatic bitx(input logic b, output logic s);
        #150 sdaPull = ~b;
        #50 scl = 1'b1;
        #200 s = sdaWire;
        scl = 1'b0;
    endtask
    // Also serves as repeated start; sda moves 150 ns after scl falls
    task automatic start();
        @(posedge clk);
        #105 sdaPull = 1'b0;
        #50 scl = 1'b1;
        #200 sdaPull = 1'b1;
        #200 scl = 1'b0;
    endtask
    task automatic stop();
        #150 sdaPull = 1'b1;
        #50 scl = 1'b1;
        #200 sdaPull = 1'b0;
        #200;
    endtask
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic getByte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            b[i] = r;
        end
        bitx(last, r);
    endtask
endmodule

// file: bench/test_pmm_mgmt.sv
// Self-checking bench for the management and transmit-disable block.
// Assumes pmm_host_model plays the host; sda and fault wires pulled up here.
`timescale 1ns/100ps
module test_pmm_mgmt;
    logic clk, sys_rst, txOffPin, laserFaultIn, lossDetectIn, ack;
    logic [15:0] mon [5];
    logic sdaOut, sdaOe, laserEnable, txFaultOut, txFaultOe, receiveSignalLost, scl, sdaPull;
    logic [7:0] q [$];
    int n_fail, comparisons;
    wire sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;
    wire faultWire = txFaultOe ? txFaultOut : 1'b1;
    pmm_host_model i_pmm_host_model (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
    pmm_mgmt i_pmm_mgmt (.clk(clk), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .txOffPin(txOffPin), .laserFaultIn(laserFaultIn), .lossDetectIn(lossDetectIn),
        .supplyVoltage(mon[1]), .temperature(mon[0]), .laserBias(mon[2]), .txPower(mon[3]),
        .rxPower(mon[4]), .laserEnable(laserEnable), .txFaultOut(txFaultOut), .txFaultOe(txFaultOe),
        .receiveSignalLost(receiveSignalLost));
    task automatic checkBit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic addr(input logic [6:0] dev, input logic rw);
        i_pmm_host_model.start();
        i_pmm_host_model.sendByte({dev, rw}, ack);
        checkBit(ack, 1'b1, "address ack");
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] off, input logic [7:0] d);
        addr(dev, 1'b0);
        i_pmm_host_model.sendByte(off, ack);
        i_pmm_host_model.sendByte(d, ack);
        checkBit(ack, 1'b1, "data ack");
        i_pmm_host_model.stop();
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] off, input int n);
        logic [7:0] b;
        q = {};
        addr(dev, 1'b0);
        i_pmm_host_model.sendByte(off, ack);
        addr(dev, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_pmm_host_model.getByte(i == n - 1, b);
            q.push_back(b);
        end
        i_pmm_host_model.stop();
    endtask
    task automatic ctrl(input logic [7:0] exp);
        rd(pmm_pkg::DEV_DIAG, pmm_pkg::CTRL_OFFSET, 1);
        checkByte(q[0], exp, "control byte");
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole sequence needs well under 1 ms of link traffic
    initial begin
        #3000000;
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end
    initial begin
        n_fail = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        txOffPin = 1'b1;
        laserFaultIn = 1'b0;
        lossDetectIn = 1'b0;
        mon = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h2468};
        tick(12);
        checkBit(txFaultOe, 1'b1, "fault in reset");
        sys_rst = 1'b0;
        tick(8);
        checkBit(laserEnable, 1'b0, "laser with pin pulled up");
        ctrl(8'h80);
        txOffPin = 1'b0;
        tick(6);
        checkBit(laserEnable, 1'b1, "laser with pin low");
        ctrl(8'h00);
        wr(pmm_pkg::DEV_DIAG, pmm_pkg::CTRL_OFFSET, 8'hff);
        checkBit(laserEnable, 1'b0, "soft disable");
        ctrl(8'h40);
        wr(pmm_pkg::DEV_DIAG, pmm_pkg::CTRL_OFFSET, 8'h00);
        checkBit(laserEnable, 1'b1, "soft enable");
        lossDetectIn = 1'b1;
        tick(6);
        checkBit(receiveSignalLost, 1'b1, "loss output");
        ctrl(8'h02);
        lossDetectIn = 1'b0;
        laserFaultIn = 1'b1;
        tick(6);
        checkBit(laserEnable, 1'b0, "laser on fault");
        laserFaultIn = 1'b0;
        tick(6);
        checkBit(receiveSignalLost, 1'b0, "loss output cleared");
        checkBit(faultWire, 1'b1, "fault latched");
        ctrl(8'h04);
        txOffPin = 1'b1;
        tick(6);
        txOffPin = 1'b0;
        tick(6);
        checkBit(faultWire, 1'b0, "fault cleared by toggle");
        checkBit(laserEnable, 1'b1, "laser retried");
        // Monitor bytes are read-only, so this write must vanish
        wr(pmm_pkg::DEV_DIAG, pmm_pkg::MON_BASE, 8'h00);
        rd(pmm_pkg::DEV_DIAG, pmm_pkg::MON_BASE, 10);
        for (int i = 0; i < 10; i++) begin
            checkByte(q[i], i % 2 ? mon[i / 2][7:0] : mon[i / 2][15:8], "monitor");
        end
        for (int i = 0; i < 3; i++) begin
            wr(pmm_pkg::DEV_ID, 8'(8'hfe + i), 8'(8'h11 * (i + 1)));
        end
        wr(pmm_pkg::DEV_DIAG, 8'hfe, 8'h5a);
        rd(pmm_pkg::DEV_ID, 8'hfe, 3);
        for (int i = 0; i < 3; i++) begin
            checkByte(q[i], 8'(8'h11 * (i + 1)), "id page wrap");
        end
        rd(pmm_pkg::DEV_DIAG, 8'hfe, 1);
        checkByte(q[0], 8'h5a, "diag page");
        i_pmm_host_model.start();
        i_pmm_host_model.sendByte(8'ha4, ack);
        checkBit(ack, 1'b0, "foreign address");
        i_pmm_host_model.stop();
        wr(pmm_pkg::DEV_DIAG, pmm_pkg::CTRL_OFFSET, 8'h40);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(8);
        checkBit(laserEnable, 1'b1, "laser after power cycle");
        ctrl(8'h00);
        finish_test();
    end
endmodule
